//--- src/hvsg_pkg.sv
// constants and types for the hv-sense gpio interlock
package hvsg_pkg;
  localparam int CLK_MHZ = 50;
  localparam int FILT_W = 12;

  // filter and blanking times in microseconds, typical figures
  localparam int WAKE_FILT_US = 16;
  localparam int WAKE_FILT_MIN_US = 13;
  localparam int WAKE_FILT_MAX_US = 20;
  localparam int WAKE_BLANK_US = 30;
  localparam int WAKE_BLANK_MIN_US = 24;
  localparam int WAKE_BLANK_MAX_US = 40;
  localparam int OC_FILT_US = 26;
  localparam int OC_FILT_MIN_US = 20;
  localparam int OC_FILT_MAX_US = 32;
  localparam int OL_FILT_US = 64;
  localparam int OL_FILT_MIN_US = 51;
  localparam int OL_FILT_MAX_US = 80;

  localparam logic [FILT_W-1:0] WAKE_FILT_CYC = FILT_W'(WAKE_FILT_US * CLK_MHZ);
  localparam logic [FILT_W-1:0] WAKE_BLANK_CYC = FILT_W'(WAKE_BLANK_US * CLK_MHZ);
  localparam logic [FILT_W-1:0] OC_FILT_CYC = FILT_W'(OC_FILT_US * CLK_MHZ);
  localparam logic [FILT_W-1:0] OL_FILT_CYC = FILT_W'(OL_FILT_US * CLK_MHZ);
  localparam logic [FILT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [FILT_W-1:0] CNT_ZERO = 12'h000;

  // filter slots
  localparam int FI_WAKE = 0;
  localparam int FI_OC = 1;
  localparam int FI_OL = 2;
  localparam int FI_NUM = 3;

  // pin function codes
  typedef enum logic [2:0] {
    PF_FO = 3'h0,
    PF_WAKE = 3'h1,
    PF_HS_CS = 3'h3,
    PF_OFF = 3'h4,
    PF_LS = 3'h6,
    PF_HS = 3'h7
  } hvsg_func_t;
  localparam hvsg_func_t FUNC_RST = PF_FO;

  // wake pull configuration codes
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;
  localparam logic [1:0] PULL_RST = 2'h0;
endpackage

//--- src/hvsg_filt_if.sv
// link between the interlock and its persistence filters
`timescale 1ns/1ps
interface hvsg_filt_if;
  logic raw;
  logic en;
  logic level;
  modport flt (input raw, input en, output level);
  modport usr (output raw, output en, input level);
endinterface

//--- src/hvsg_filter.sv
// persistence filter counted on the system clock
`timescale 1ns/1ps
module hvsg_filter #(
  parameter logic [11:0] CNT = 12'h001,
  parameter bit HOLD_OFF = 1'b1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  hvsg_filt_if.flt f
);
  import hvsg_pkg::*;

  logic [FILT_W-1:0] cnt_r, cnt_nxt;
  logic level_r, level_nxt;

  always_comb begin
    cnt_nxt = CNT_ZERO;
    level_nxt = level_r;
    if (!f.en) begin
      // switch filters forget, the wake filter keeps its last level as reference
      level_nxt = HOLD_OFF ? level_r : 1'b0;
    end else if (f.raw != level_r) begin
      if (cnt_r == CNT - CNT_ONE) begin
        level_nxt = f.raw;
      end else begin
        cnt_nxt = cnt_r + CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= CNT_ZERO;
      level_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      level_r <= level_nxt;
    end
  end

  assign f.level = level_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  flt_len_a: assert property ($changed(level_r) && $past(f.en) |-> $past(cnt_r) == CNT - CNT_ONE)
    else $error("filter level changed before its count elapsed");
  flt_range_a: assert property (cnt_r < CNT)
    else $error("filter counter past its limit");
endmodule

//--- src/hvsg_interlock.sv
// hv-sense interlock, wake gating and diagnostic filters of the fail/gpio pin
`timescale 1ns/1ps
// Function
// - sensing on: wake pull sources off, internal wake signal blocked.
// - sensing on: wake pull writes stored but have no effect.
// - pin function writes refused while sensing enable is one.
// - sensing enable refused with error while pin is fail output.
// - sensing on: wake detection off, wake event and level status frozen.
// - sensing on and gpio wake only source: sleep gives error and restart.
// - wake input level changes filtered 16 us before acceptance.
// - wake detection blanked 30 us after enabling wake input.
// - overcurrent must persist 26 us before switch shutdown.
// - high-side on-state open load must persist 64 us before report.
// - all filter and blanking times counted on the internal clock.
// - sensing on: fail output, its test and gpio unavailable; attempts flag error.
module hvsg_interlock (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic func_wr,
  input wire hvsg_pkg::hvsg_func_t func_wdata,
  input wire logic pull_wr,
  input wire logic [1:0] pull_wdata,
  input wire logic sense_wr,
  input wire logic sense_wdata,
  input wire logic fo_test_wr,
  input wire logic fo_test_wdata,
  input wire logic cmd_error_clr,
  input wire logic wake_event_clr,
  input wire logic flags_clr,
  input wire logic sleep_req,
  input wire logic gpio_wake_only,
  input wire logic fail_event,
  input wire logic sw_drive,
  input wire logic gpio_level_in,
  input wire logic hv_wake_pin_in,
  input wire logic oc_detect,
  input wire logic ol_detect,
  output hvsg_pkg::hvsg_func_t pin_func,
  output logic [1:0] wake_pull_config,
  output logic hv_sense_enable,
  output logic fail_output_test,
  output logic pull_up_en,
  output logic pull_dn_en,
  output logic hv_wake_sig,
  output logic wake_event_status,
  output logic wake_level_status,
  output logic cmd_error,
  output logic oc_flag,
  output logic ol_flag,
  output logic ls_on,
  output logic hs_on,
  output logic fail_output,
  output logic sleep_ack,
  output logic restart_req
);
  import hvsg_pkg::*;

  function automatic logic [FILT_W-1:0] filt_cnt(input int idx);
    logic [FILT_W-1:0] c;
    c = WAKE_FILT_CYC;
    if (idx == FI_OC) begin
      c = OC_FILT_CYC;
    end else if (idx == FI_OL) begin
      c = OL_FILT_CYC;
    end
    return c;
  endfunction

  function automatic logic is_switch(input hvsg_func_t fn);
    return (fn == PF_LS) || (fn == PF_HS) || (fn == PF_HS_CS);
  endfunction

  hvsg_func_t func_r, func_nxt;
  logic [1:0] pull_r, pull_nxt;
  logic sense_r, sense_nxt;
  logic fo_test_r, fo_test_nxt;
  logic cmd_err_r, cmd_err_nxt;
  logic wk_evt_r, wk_evt_nxt;
  logic wk_lvl_r, wk_lvl_nxt;
  logic prev_lvl_r, prev_lvl_nxt;
  logic wk_act_r, wk_act_nxt;
  logic blank_r, blank_nxt;
  logic [FILT_W-1:0] blank_cnt_r, blank_cnt_nxt;
  logic oc_r, oc_nxt;
  logic ol_r, ol_nxt;
  logic sleep_ack_r, sleep_ack_nxt;
  logic restart_r, restart_nxt;

  logic wk_act;
  logic sw_on;
  logic err_set;

  hvsg_filt_if fif[FI_NUM] ();

  // one persistence filter each for the wake input and the overcurrent and open load inputs
  for (genvar g = 0; g < FI_NUM; g++) begin : g_filt
    hvsg_filter #(
      .CNT(filt_cnt(g)),
      .HOLD_OFF(g == FI_WAKE)
    ) u_filt (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .f(fif[g])
    );
  end

  // wake path only lives while the pin is a wake input and sensing is off
  assign wk_act = (func_r == PF_WAKE) && !sense_r;
  assign sw_on = is_switch(func_r) && !sense_r && sw_drive;

  assign fif[FI_WAKE].raw = gpio_level_in;
  assign fif[FI_WAKE].en = wk_act;
  // diagnosis only during the on-time
  assign fif[FI_OC].raw = oc_detect;
  assign fif[FI_OC].en = sw_on;
  assign fif[FI_OL].raw = ol_detect;
  assign fif[FI_OL].en = sw_on && (func_r == PF_HS);

  always_comb begin
    func_nxt = func_r;
    pull_nxt = pull_r;
    sense_nxt = sense_r;
    fo_test_nxt = fo_test_r;
    err_set = 1'b0;
    sleep_ack_nxt = 1'b0;
    restart_nxt = 1'b0;
    if (pull_wr) begin
      pull_nxt = pull_wdata;
    end
    if (func_wr) begin
      if (sense_r) begin
        err_set = 1'b1;
      end else begin
        func_nxt = func_wdata;
      end
    end
    // sensing may not start over a fail output
    if (sense_wr) begin
      if (sense_wdata && !sense_r && func_r == PF_FO) begin
        err_set = 1'b1;
      end else begin
        sense_nxt = sense_wdata;
      end
    end
    // fail output test refused during sensing
    if (fo_test_wr) begin
      if (sense_r && fo_test_wdata) begin
        err_set = 1'b1;
      end else begin
        fo_test_nxt = fo_test_wdata;
      end
    end
    // filtered overcurrent turns the switch off
    if (fif[FI_OC].level) begin
      func_nxt = PF_OFF;
    end
    // sleep would leave no wake source
    if (sleep_req) begin
      if (sense_r && gpio_wake_only) begin
        err_set = 1'b1;
        restart_nxt = 1'b1;
      end else begin
        sleep_ack_nxt = 1'b1;
      end
    end
    // set wins over clear
    cmd_err_nxt = err_set || (cmd_err_r && !cmd_error_clr);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      func_r <= FUNC_RST;
      pull_r <= PULL_RST;
      sense_r <= 1'b0;
      fo_test_r <= 1'b0;
      cmd_err_r <= 1'b0;
      sleep_ack_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      func_r <= func_nxt;
      pull_r <= pull_nxt;
      sense_r <= sense_nxt;
      fo_test_r <= fo_test_nxt;
      cmd_err_r <= cmd_err_nxt;
      sleep_ack_r <= sleep_ack_nxt;
      restart_r <= restart_nxt;
    end
  end

  always_comb begin
    wk_act_nxt = wk_act;
    prev_lvl_nxt = fif[FI_WAKE].level;
    blank_nxt = blank_r;
    blank_cnt_nxt = blank_cnt_r;
    wk_lvl_nxt = wk_lvl_r;
    // blanking restarts on every activation, also after sensing ends
    if (wk_act && !wk_act_r) begin
      blank_nxt = 1'b1;
      blank_cnt_nxt = CNT_ZERO;
    end else if (blank_r) begin
      if (!wk_act || blank_cnt_r == WAKE_BLANK_CYC - CNT_ONE) begin
        blank_nxt = 1'b0;
        blank_cnt_nxt = CNT_ZERO;
      end else begin
        blank_cnt_nxt = blank_cnt_r + CNT_ONE;
      end
    end
    if (wk_act) begin
      wk_lvl_nxt = fif[FI_WAKE].level;
    end
    // event only on a filtered change outside blanking
    wk_evt_nxt = (wk_act && !blank_r && fif[FI_WAKE].level != prev_lvl_r)
      || (wk_evt_r && !wake_event_clr);
    oc_nxt = fif[FI_OC].level || (oc_r && !flags_clr);
    ol_nxt = fif[FI_OL].level || (ol_r && !flags_clr);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wk_act_r <= 1'b0;
      prev_lvl_r <= 1'b0;
      blank_r <= 1'b0;
      blank_cnt_r <= CNT_ZERO;
      wk_lvl_r <= 1'b0;
      wk_evt_r <= 1'b0;
      oc_r <= 1'b0;
      ol_r <= 1'b0;
    end else begin
      wk_act_r <= wk_act_nxt;
      prev_lvl_r <= prev_lvl_nxt;
      blank_r <= blank_nxt;
      blank_cnt_r <= blank_cnt_nxt;
      wk_lvl_r <= wk_lvl_nxt;
      wk_evt_r <= wk_evt_nxt;
      oc_r <= oc_nxt;
      ol_r <= ol_nxt;
    end
  end

  assign pin_func = func_r;
  assign wake_pull_config = pull_r;
  assign hv_sense_enable = sense_r;
  assign fail_output_test = fo_test_r;
  // pull sources follow the stored setting only without sensing
  assign pull_up_en = !sense_r && pull_r == PULL_UP;
  assign pull_dn_en = !sense_r && pull_r == PULL_DN;
  // wake signal gated at the source
  assign hv_wake_sig = hv_wake_pin_in && !sense_r;
  assign wake_event_status = wk_evt_r;
  assign wake_level_status = wk_lvl_r;
  assign cmd_error = cmd_err_r;
  assign oc_flag = oc_r;
  assign ol_flag = ol_r;
  assign ls_on = sw_on && func_r == PF_LS;
  assign hs_on = sw_on && func_r != PF_LS;
  assign fail_output = func_r == PF_FO && !sense_r && (fail_event || fo_test_r);
  assign sleep_ack = sleep_ack_r;
  assign restart_req = restart_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  pull_off_a: assert property (hv_sense_enable |-> !pull_up_en && !pull_dn_en && !hv_wake_sig)
    else $error("pull or wake path active while sensing");
  pull_store_a: assert property (pull_wr && hv_sense_enable |=> wake_pull_config == $past(pull_wdata))
    else $error("pull write lost during sensing");
  func_lock_a: assert property (func_wr && hv_sense_enable |=> $stable(pin_func) && cmd_error)
    else $error("pin function changed while sensing");
  sense_reject_a: assert property (sense_wr && sense_wdata && !hv_sense_enable && pin_func == PF_FO
    |=> !hv_sense_enable && cmd_error)
    else $error("sensing enabled over fail output");
  status_hold_a: assert property (hv_sense_enable && !wake_event_clr
    |=> $stable(wake_event_status) && $stable(wake_level_status))
    else $error("wake status moved while sensing");
  sleep_block_a: assert property (sleep_req && hv_sense_enable && gpio_wake_only
    |=> restart_req && cmd_error && !sleep_ack ##1 !restart_req)
    else $error("sleep taken without wake source");
  blank_len_a: assert property ($fell(blank_r) && wk_act |-> $past(blank_cnt_r) == WAKE_BLANK_CYC - CNT_ONE)
    else $error("blanking ended early");
  oc_shut_a: assert property (fif[FI_OC].level |=> pin_func == PF_OFF && oc_flag)
    else $error("overcurrent did not shut the switch");
  ol_report_a: assert property (fif[FI_OL].level |=> ol_flag)
    else $error("open load not reported");
  fo_gate_a: assert property (hv_sense_enable |-> !fail_output && !ls_on && !hs_on)
    else $error("fail output or switch live while sensing");
  resume_a: assert property ($fell(hv_sense_enable) && pin_func == PF_WAKE |=> blank_r)
    else $error("no blanking after sensing ends");

  sense_on_c: cover property (sense_wr && sense_wdata && pin_func == PF_OFF ##1 hv_sense_enable);
  sleep_blk_c: cover property (sleep_req && hv_sense_enable && gpio_wake_only);
  wake_evt_c: cover property ($rose(wake_event_status));
  oc_shut_c: cover property ($rose(oc_flag));
endmodule

//--- verif/hvsg_mcu.sv
// controller-side model issuing configuration writes to the interlock
`timescale 1ns/1ps
module hvsg_mcu (
  input wire logic clk_sys,
  output logic func_wr,
  output hvsg_pkg::hvsg_func_t func_wdata,
  output logic pull_wr,
  output logic [1:0] pull_wdata,
  output logic sense_wr,
  output logic sense_wdata,
  output logic fo_test_wr,
  output logic fo_test_wdata,
  output logic cmd_error_clr,
  output logic sleep_req
);
  import hvsg_pkg::*;
  initial begin
    {func_wr, pull_wr, sense_wr, fo_test_wr, cmd_error_clr, sleep_req} = 6'h00;
    {pull_wdata, sense_wdata, fo_test_wdata} = 4'h0;
    func_wdata = PF_FO;
  end
  // kind: 0 func, 1 pull, 2 sense, 3 fail test, 4 error clear, 5 sleep
  task automatic wr(input int kind, input logic [2:0] d);
    @(posedge clk_sys);
    case (kind)
      0: begin
        func_wr <= 1'b1;
        func_wdata <= hvsg_func_t'(d);
      end
      1: begin
        pull_wr <= 1'b1;
        pull_wdata <= d[1:0];
      end
      2: begin
        sense_wr <= 1'b1;
        sense_wdata <= d[0];
      end
      3: begin
        fo_test_wr <= 1'b1;
        fo_test_wdata <= d[0];
      end
      4: cmd_error_clr <= 1'b1;
      default: sleep_req <= 1'b1;
    endcase
    // strobe is taken here; the answer is visible right after this edge
    @(posedge clk_sys);
    {func_wr, pull_wr, sense_wr, fo_test_wr, cmd_error_clr, sleep_req} <= 6'h00;
    #1;
  endtask
endmodule

//--- verif/tb.sv
// self-checking bench for the hv-sense interlock
`timescale 1ns/1ps
module tb;
  import hvsg_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic gpio_wake_only = 1'b0, fail_event = 1'b0, sw_drive = 1'b0, gpio_level_in = 1'b1;
  logic hv_wake_pin_in = 1'b1, oc_detect = 1'b0, ol_detect = 1'b0, wake_event_clr = 1'b0, flags_clr = 1'b0;
  logic func_wr, pull_wr, sense_wr, sense_wdata, fo_test_wr, fo_test_wdata, cmd_error_clr, sleep_req;
  logic [1:0] pull_wdata, wake_pull_config;
  hvsg_func_t func_wdata, pin_func;
  logic hv_sense_enable, fail_output_test, pull_up_en, pull_dn_en, hv_wake_sig, wake_event_status;
  logic wake_level_status, cmd_error, oc_flag, ol_flag, ls_on, hs_on, fail_output, sleep_ack, restart_req;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;

  always #10 clk_sys = ~clk_sys;

  hvsg_mcu mcu (.clk_sys(clk_sys), .func_wr(func_wr), .func_wdata(func_wdata), .pull_wr(pull_wr),
    .pull_wdata(pull_wdata), .sense_wr(sense_wr), .sense_wdata(sense_wdata), .fo_test_wr(fo_test_wr),
    .fo_test_wdata(fo_test_wdata), .cmd_error_clr(cmd_error_clr), .sleep_req(sleep_req));

  hvsg_interlock dut (.clk_sys(clk_sys), .resetn(resetn), .func_wr(func_wr), .func_wdata(func_wdata),
    .pull_wr(pull_wr), .pull_wdata(pull_wdata), .sense_wr(sense_wr), .sense_wdata(sense_wdata),
    .fo_test_wr(fo_test_wr), .fo_test_wdata(fo_test_wdata), .cmd_error_clr(cmd_error_clr),
    .wake_event_clr(wake_event_clr), .flags_clr(flags_clr), .sleep_req(sleep_req),
    .gpio_wake_only(gpio_wake_only), .fail_event(fail_event), .sw_drive(sw_drive),
    .gpio_level_in(gpio_level_in), .hv_wake_pin_in(hv_wake_pin_in), .oc_detect(oc_detect),
    .ol_detect(ol_detect), .pin_func(pin_func), .wake_pull_config(wake_pull_config),
    .hv_sense_enable(hv_sense_enable), .fail_output_test(fail_output_test), .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en), .hv_wake_sig(hv_wake_sig), .wake_event_status(wake_event_status),
    .wake_level_status(wake_level_status), .cmd_error(cmd_error), .oc_flag(oc_flag), .ol_flag(ol_flag),
    .ls_on(ls_on), .hs_on(hs_on), .fail_output(fail_output), .sleep_ack(sleep_ack), .restart_req(restart_req));

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // whole run needs about 12000 cycles; ceiling leaves margin
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    cycles(3);
    @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    chk(pin_func, PF_FO);
    chk(fail_output, 1'b0);
    mcu.wr(3, 3'h1);
    chk({fail_output_test, fail_output}, 2'h3);
    mcu.wr(3, 3'h0);
    @(posedge clk_sys);
    fail_event <= 1'b1;
    cycles(1);
    chk({fail_output_test, fail_output}, 2'h1);
    mcu.wr(2, 3'h1);
    chk(hv_sense_enable, 1'b0);
    chk(cmd_error, 1'b1);
    mcu.wr(4, 3'h0);
    chk(cmd_error, 1'b0);
    mcu.wr(1, PULL_UP);
    chk(pull_up_en, 1'b1);
    chk(hv_wake_sig, 1'b1);
    // level already high at entry: it qualifies inside the blanking time
    mcu.wr(0, PF_WAKE);
    cycles(1000);
    chk(wake_level_status, 1'b1);
    chk(wake_event_status, 1'b0);
    cycles(600);
    @(posedge clk_sys);
    gpio_level_in <= 1'b0;
    cycles(798);
    chk(wake_level_status, 1'b1);
    cycles(5);
    chk(wake_level_status, 1'b0);
    chk(wake_event_status, 1'b1);
    @(posedge clk_sys);
    wake_event_clr <= 1'b1;
    @(posedge clk_sys);
    wake_event_clr <= 1'b0;
    mcu.wr(2, 3'h1);
    chk(hv_sense_enable, 1'b1);
    chk(cmd_error, 1'b0);
    chk(wake_event_status, 1'b0);
    chk({pull_up_en, hv_wake_sig}, 2'h0);
    mcu.wr(1, PULL_DN);
    chk(wake_pull_config, PULL_DN);
    chk(pull_dn_en, 1'b0);
    mcu.wr(0, PF_HS);
    chk(pin_func, PF_WAKE);
    chk(cmd_error, 1'b1);
    mcu.wr(4, 3'h0);
    mcu.wr(3, 3'h1);
    chk(fail_output_test, 1'b0);
    chk({cmd_error, fail_output}, 2'h2);
    mcu.wr(4, 3'h0);
    @(posedge clk_sys);
    gpio_level_in <= 1'b1;
    cycles(1000);
    chk({wake_level_status, wake_event_status}, 2'h0);
    @(posedge clk_sys);
    gpio_wake_only <= 1'b1;
    mcu.wr(5, 3'h0);
    chk({restart_req, sleep_ack, cmd_error}, 3'h5);
    cycles(1);
    chk(restart_req, 1'b0);
    mcu.wr(4, 3'h0);
    @(posedge clk_sys);
    gpio_wake_only <= 1'b0;
    mcu.wr(5, 3'h0);
    chk({restart_req, sleep_ack, cmd_error}, 3'h2);
    mcu.wr(2, 3'h0);
    chk({pull_dn_en, hv_wake_sig}, 2'h3);
    cycles(2400);
    // level taken, event dropped by blanking
    chk({wake_level_status, wake_event_status}, 2'h2);
    // high-side switch: open load, then overcurrent shutdown
    mcu.wr(0, PF_HS);
    @(posedge clk_sys);
    sw_drive <= 1'b1;
    ol_detect <= 1'b1;
    cycles(3190);
    chk({hs_on, ol_flag}, 2'h2);
    cycles(20);
    chk(ol_flag, 1'b1);
    @(posedge clk_sys);
    oc_detect <= 1'b1;
    cycles(1290);
    chk({pin_func, oc_flag}, {PF_HS, 1'b0});
    cycles(20);
    chk({pin_func, oc_flag, hs_on}, {PF_OFF, 2'h2});
    @(posedge clk_sys);
    flags_clr <= 1'b1;
    @(posedge clk_sys);
    flags_clr <= 1'b0;
    #1;
    chk({oc_flag, ol_flag}, 2'h0);
    mcu.wr(0, PF_LS);
    chk({ls_on, hs_on}, 2'h2);
    cycles(1290);
    chk({pin_func, oc_flag}, {PF_LS, 1'b0});
    cycles(20);
    chk({pin_func, oc_flag, ls_on, ol_flag}, {PF_OFF, 3'h4});
    final_report();
  end
endmodule
